/* common/bstap_pkg.sv */
// constants, states and carrier types of the boundary-scan test port
package bstap_pkg;
    localparam int BSTAP_BSR_LEN = 115;
    localparam int BSTAP_EN_CELLS = 3;
    localparam int BSTAP_EN_LSB = BSTAP_BSR_LEN - BSTAP_EN_CELLS;
    localparam int BSTAP_IR_LEN = 4;
    localparam int BSTAP_ID_LEN = 32;
    localparam int BSTAP_SYNC_W = BSTAP_BSR_LEN + 3;
    localparam logic [3:0] BSTAP_OP_EXTEST = 4'h0;
    localparam logic [3:0] BSTAP_OP_SAMPLE = 4'h1;
    localparam logic [3:0] BSTAP_OP_BYPASS = 4'hf;
    localparam logic [3:0] BSTAP_IR_CAPTURE = 4'h1;
    localparam logic [1:0] BSTAP_IR_CAP_LOW = 2'h1;
    localparam logic [2:0] BSTAP_TMS_RESET_CNT = 3'h5;
    localparam logic [2:0] BSTAP_TMS_CNT_MAX = 3'h7;
    typedef enum logic [15:0] {
        TAP_TLR = 16'h0001,
        TAP_RTI = 16'h0002,
        TAP_SDR = 16'h0004,
        TAP_CDR = 16'h0008,
        TAP_SHDR = 16'h0010,
        TAP_E1DR = 16'h0020,
        TAP_PDR = 16'h0040,
        TAP_E2DR = 16'h0080,
        TAP_UDR = 16'h0100,
        TAP_SIR = 16'h0200,
        TAP_CIR = 16'h0400,
        TAP_SHIR = 16'h0800,
        TAP_E1IR = 16'h1000,
        TAP_PIR = 16'h2000,
        TAP_E2IR = 16'h4000,
        TAP_UIR = 16'h8000
    } bstap_state_type;
    typedef struct packed {
        logic [BSTAP_BSR_LEN-1:0] pad;
        logic tck;
        logic tms;
        logic tdi;
    } bstap_pins_type;
endpackage : bstap_pkg

/* core/bstap_top.sv */
// boundary-scan test access port with controller, instruction, bypass, id and boundary registers
`timescale 1ns/1ns
// Notes on behaviour
// RULE1: sample tdi and tms at rising tck
// RULE2: tdo changes only at falling tck
// RULE3: state moves at rising tck per tms
// RULE4: sixteen-state controller, data and instruction columns
// RULE5: 0000 extest, 0001 sample, 1111 bypass
// RULE6: instruction register is four bits wide
// RULE7: instruction shifts in lsb first
// RULE8: current instruction picks the data register
// RULE9: bypass is one stage tdi to tdo
// RULE10: boundary chain has 115 cells
// RULE11: tdi enters lsb cell, msb feeds tdo
// RULE12: capture-dr loads pad inputs into cells
// RULE13: scanned cells can drive the pins
// RULE14: trst low resets controller asynchronously
// RULE15: five tms-high edges reach reset, stays
// RULE16: reset state selects the id register
// RULE17: reset clears top three cells, outputs off
// RULE18: reset holds on tms high, else idle
// RULE19: idle holds on tms low, else select-dr
// RULE20: idle leaves data registers unchanged
// RULE21: select-dr: low capture-dr, high select-ir
// RULE22: select-ir: low capture-ir, high reset
// RULE23: capture-ir loads 01 into low bits
// RULE24: update-dr latches outputs at falling tck
// RULE25: update-ir makes shifted code the instruction
// RULE26: capture-dr: low shift-dr, high exit1-dr
// RULE27: reserved codes select bypass register
// RULE28: remaining states follow the standard graph
module bstap_top
    import bstap_pkg::*;
#(
    // arbitrary neutral identification value
    parameter logic [BSTAP_ID_LEN-1:0] ID_VALUE = 32'h0000_0001
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    input wire logic trst_n_in,
    input wire logic [BSTAP_BSR_LEN-1:0] pad_in,
    input wire logic [BSTAP_BSR_LEN-1:0] sys_data_in,
    input wire logic [BSTAP_EN_CELLS-1:0] sys_en_in,
    output logic tdo_out,
    output logic tdo_en_out,
    output logic [BSTAP_BSR_LEN-1:0] pad_data_out,
    output logic [BSTAP_EN_CELLS-1:0] pad_en_out
);
    bstap_pins_type raw_pins;
    bstap_pins_type sync1_ff;
    bstap_pins_type sync2_ff;
    bstap_pins_type sync3_ff;
    bstap_pins_type flt_ff;
    logic tck_d_ff;
    logic tck_rise;
    logic tck_fall;
    logic tap_rst_n;
    bstap_state_type state_ff;
    bstap_state_type nxt_state;
    logic [BSTAP_IR_LEN-1:0] ir_sh_ff;
    logic [BSTAP_IR_LEN-1:0] ir_ff;
    logic idsel_ff;
    logic byp_ff;
    logic [BSTAP_ID_LEN-1:0] id_sh_ff;
    logic [BSTAP_BSR_LEN-1:0] bsr_sh_ff;
    logic [BSTAP_BSR_LEN-1:0] bsr_upd_ff;
    logic tdo_ff;
    logic tdo_en_ff;
    logic [BSTAP_BSR_LEN-1:0] pad_data_ff;
    logic [BSTAP_EN_CELLS-1:0] pad_en_ff;
    logic sel_bsr;
    logic extest_on;
    logic ser_out;
    logic [2:0] tms_cnt_ff;

    assign raw_pins = '{pad: pad_in, tck: tck_in, tms: tms_in, tdi: tdi_in};
    assign tap_rst_n = nrst_in & trst_n_in; // [RULE14]

    // three-stage synchroniser; a change counts once stages two and three agree
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
        end else begin
            sync1_ff <= raw_pins;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flt_ff <= '0;
            tck_d_ff <= 1'b0;
        end else begin
            flt_ff <= (~(sync2_ff ^ sync3_ff) & sync3_ff) | ((sync2_ff ^ sync3_ff) & flt_ff);
            tck_d_ff <= flt_ff.tck;
        end
    end

    assign tck_rise = flt_ff.tck & ~tck_d_ff; // [RULE1]
    assign tck_fall = ~flt_ff.tck & tck_d_ff;

    // controller state graph
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            TAP_TLR: nxt_state = flt_ff.tms ? TAP_TLR : TAP_RTI; // [RULE18]
            TAP_RTI: nxt_state = flt_ff.tms ? TAP_SDR : TAP_RTI; // [RULE19]
            TAP_SDR: nxt_state = flt_ff.tms ? TAP_SIR : TAP_CDR; // [RULE21]
            TAP_CDR: nxt_state = flt_ff.tms ? TAP_E1DR : TAP_SHDR; // [RULE26]
            TAP_SHDR: nxt_state = flt_ff.tms ? TAP_E1DR : TAP_SHDR; // [RULE28]
            TAP_E1DR: nxt_state = flt_ff.tms ? TAP_UDR : TAP_PDR; // [RULE28]
            TAP_PDR: nxt_state = flt_ff.tms ? TAP_E2DR : TAP_PDR; // [RULE28]
            TAP_E2DR: nxt_state = flt_ff.tms ? TAP_UDR : TAP_SHDR; // [RULE28]
            TAP_UDR: nxt_state = flt_ff.tms ? TAP_SDR : TAP_RTI; // [RULE28]
            TAP_SIR: nxt_state = flt_ff.tms ? TAP_TLR : TAP_CIR; // [RULE22]
            TAP_CIR: nxt_state = flt_ff.tms ? TAP_E1IR : TAP_SHIR; // [RULE26]
            TAP_SHIR: nxt_state = flt_ff.tms ? TAP_E1IR : TAP_SHIR; // [RULE28]
            TAP_E1IR: nxt_state = flt_ff.tms ? TAP_UIR : TAP_PIR; // [RULE28]
            TAP_PIR: nxt_state = flt_ff.tms ? TAP_E2IR : TAP_PIR; // [RULE28]
            TAP_E2IR: nxt_state = flt_ff.tms ? TAP_UIR : TAP_SHIR; // [RULE28]
            TAP_UIR: nxt_state = flt_ff.tms ? TAP_SDR : TAP_RTI; // [RULE28]
            default: nxt_state = TAP_TLR;
        endcase
    end

    always_ff @(posedge clk_in or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            state_ff <= TAP_TLR; // [RULE14]
        end else if (tck_rise) begin
            state_ff <= nxt_state; // [RULE3] [RULE4]
        end
    end

    // instruction path: capture, lsb-first shift, update at falling tck
    always_ff @(posedge clk_in or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_sh_ff <= BSTAP_IR_CAPTURE;
        end else if (tck_rise && state_ff == TAP_CIR) begin
            ir_sh_ff <= BSTAP_IR_CAPTURE; // [RULE23]
        end else if (tck_rise && state_ff == TAP_SHIR) begin
            ir_sh_ff <= {flt_ff.tdi, ir_sh_ff[BSTAP_IR_LEN-1:1]}; // [RULE7] [RULE6]
        end
    end

    always_ff @(posedge clk_in or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_ff <= BSTAP_OP_BYPASS;
            idsel_ff <= 1'b1;
        end else if (state_ff == TAP_TLR) begin
            ir_ff <= BSTAP_OP_BYPASS;
            idsel_ff <= 1'b1; // [RULE16]
        end else if (tck_fall && state_ff == TAP_UIR) begin
            ir_ff <= ir_sh_ff; // [RULE25]
            idsel_ff <= 1'b0;
        end
    end

    // instruction decode; reserved codes fall to bypass
    assign sel_bsr = ~idsel_ff & (ir_ff == BSTAP_OP_EXTEST || ir_ff == BSTAP_OP_SAMPLE); // [RULE5] [RULE8] [RULE27]
    assign extest_on = ~idsel_ff & (ir_ff == BSTAP_OP_EXTEST);

    // data registers shift only while selected; idle and pause leave them alone
    always_ff @(posedge clk_in or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            byp_ff <= 1'b0;
        end else if (tck_rise && !sel_bsr && !idsel_ff) begin
            if (state_ff == TAP_CDR) begin
                byp_ff <= 1'b0;
            end else if (state_ff == TAP_SHDR) begin
                byp_ff <= flt_ff.tdi; // [RULE9]
            end
        end
    end

    always_ff @(posedge clk_in or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            id_sh_ff <= ID_VALUE;
        end else if (tck_rise && idsel_ff) begin
            if (state_ff == TAP_CDR) begin
                id_sh_ff <= ID_VALUE;
            end else if (state_ff == TAP_SHDR) begin
                id_sh_ff <= {flt_ff.tdi, id_sh_ff[BSTAP_ID_LEN-1:1]};
            end
        end
    end

    always_ff @(posedge clk_in or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            bsr_sh_ff <= '0;
        end else if (state_ff == TAP_TLR) begin
            bsr_sh_ff[BSTAP_BSR_LEN-1:BSTAP_EN_LSB] <= '0; // [RULE17]
        end else if (tck_rise && sel_bsr) begin
            if (state_ff == TAP_CDR) begin
                bsr_sh_ff <= flt_ff.pad; // [RULE12]
            end else if (state_ff == TAP_SHDR) begin
                bsr_sh_ff <= {bsr_sh_ff[BSTAP_BSR_LEN-2:0], flt_ff.tdi}; // [RULE10] [RULE11]
            end
        end
    end

    always_ff @(posedge clk_in or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            bsr_upd_ff <= '0;
        end else if (state_ff == TAP_TLR) begin
            bsr_upd_ff[BSTAP_BSR_LEN-1:BSTAP_EN_LSB] <= '0; // [RULE17]
        end else if (tck_fall && sel_bsr && state_ff == TAP_UDR) begin
            bsr_upd_ff <= bsr_sh_ff; // [RULE24] [RULE20]
        end
    end

    // serial output mux, driven out at falling tck
    always_comb begin
        ser_out = byp_ff;
        if (state_ff == TAP_SHIR) begin
            ser_out = ir_sh_ff[0];
        end else if (idsel_ff) begin
            ser_out = id_sh_ff[0];
        end else if (sel_bsr) begin
            ser_out = bsr_sh_ff[BSTAP_BSR_LEN-1]; // [RULE11]
        end
    end

    always_ff @(posedge clk_in or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            tdo_ff <= 1'b0;
            tdo_en_ff <= 1'b0;
        end else if (tck_fall) begin
            tdo_ff <= ser_out; // [RULE2]
            tdo_en_ff <= (state_ff == TAP_SHDR) || (state_ff == TAP_SHIR);
        end
    end

    // pins carry scanned values under extest, the core values otherwise
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pad_data_ff <= '0;
            pad_en_ff <= '0;
        end else if (extest_on) begin
            pad_data_ff <= bsr_upd_ff; // [RULE13]
            pad_en_ff <= bsr_upd_ff[BSTAP_BSR_LEN-1:BSTAP_EN_LSB];
        end else begin
            pad_data_ff <= sys_data_in;
            pad_en_ff <= sys_en_in;
        end
    end

    assign tdo_out = tdo_ff;
    assign tdo_en_out = tdo_en_ff;
    assign pad_data_out = pad_data_ff;
    assign pad_en_out = pad_en_ff;

    // helper: consecutive rising edges with tms high
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tms_cnt_ff <= '0;
        end else if (tck_rise) begin
            if (!flt_ff.tms) begin
                tms_cnt_ff <= '0;
            end else if (tms_cnt_ff != BSTAP_TMS_CNT_MAX) begin
                tms_cnt_ff <= tms_cnt_ff + 3'h1;
            end
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!tap_rst_n);

    sequence s_rise_hi;
        tck_rise && flt_ff.tms;
    endsequence
    sequence s_rise_lo;
        tck_rise && !flt_ff.tms;
    endsequence

    chk_tlr_hold: assert property (((state_ff == TAP_TLR) and s_rise_hi) |=> state_ff == TAP_TLR) // [RULE18]
        else $error("reset state left with tms high");
    chk_tlr_to_idle: assert property (((state_ff == TAP_TLR) and s_rise_lo) |=> state_ff == TAP_RTI) // [RULE18]
        else $error("reset state did not go to idle");
    chk_five_ones: assert property (tms_cnt_ff >= BSTAP_TMS_RESET_CNT |-> state_ff == TAP_TLR) // [RULE15]
        else $error("five tms-high edges did not reach reset");
    chk_tdo_edge: assert property (!$stable(tdo_ff) |-> $past(tck_fall)) // [RULE2]
        else $error("tdo changed away from a falling tck");
    chk_capir_value: assert property ((state_ff == TAP_CIR) && tck_rise
            |=> ir_sh_ff[1:0] == BSTAP_IR_CAP_LOW) // [RULE23]
        else $error("capture-ir low bits wrong");
    chk_bypass_stage: assert property ((state_ff == TAP_SHDR) && tck_rise && !sel_bsr && !idsel_ff
            |=> byp_ff == $past(flt_ff.tdi)) // [RULE9]
        else $error("bypass stage did not take tdi");
    chk_upd_hold: assert property ((state_ff != TAP_UDR) && (state_ff != TAP_TLR)
            |=> $stable(bsr_upd_ff)) // [RULE24]
        else $error("boundary outputs moved outside update-dr");
    chk_tlr_cells: assert property ((state_ff == TAP_TLR)
            |=> bsr_upd_ff[BSTAP_BSR_LEN-1:BSTAP_EN_LSB] == '0) // [RULE17]
        else $error("top cells not cleared in reset state");
    chk_sel_dr: assert property (((state_ff == TAP_SDR) and s_rise_lo) |=> state_ff == TAP_CDR) // [RULE21]
        else $error("select-dr did not go to capture-dr");
    chk_sel_ir: assert property (((state_ff == TAP_SIR) and s_rise_hi) |=> state_ff == TAP_TLR) // [RULE22]
        else $error("select-ir did not return to reset");
    chk_idle_stay: assert property (((state_ff == TAP_RTI) and s_rise_lo) |=> state_ff == TAP_RTI) // [RULE19]
        else $error("idle left with tms low");
    chk_id_default: assert property ((state_ff == TAP_TLR) |=> idsel_ff) // [RULE16]
        else $error("id register not selected in reset state");
endmodule : bstap_top

/* tb/bstap_tester.sv */
// behavioural model of the external boundary-scan tester that drives the test port pins
`timescale 1ns/1ns
module bstap_tester (
    input wire logic clk_in,
    input wire logic tdo_in,
    input wire logic tdo_en_in,
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out
);
    logic tdo_seen;
    logic en_seen;
    logic en_shift;
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // start a frame just after a system clock edge so no pin edge meets a sampling edge
    task automatic align();
        @(posedge clk_in);
        #1;
    endtask : align
    // one test clock: tms and tdi stand through the rising edge, tdo read at that edge
    task automatic tick(input logic tms, input logic tdi);
        tms_out = tms;
        tdi_out = tdi;
        #62;
        tck_out = 1'b1;
        tdo_seen = tdo_in;
        en_seen = tdo_en_in;
        #63;
        tck_out = 1'b0;
    endtask : tick
    // released data line shows the inverse of its last value
    task automatic nav(input logic tms);
        tick(tms, ~tdi_out);
    endtask : nav
    task automatic idle();
        align();
        nav(1'b0);
    endtask : idle
    // full scan from idle back to idle; din bit 0 goes first
    task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
        dout = '0;
        align();
        nav(1'b1);
        if (ir) begin
            nav(1'b1);
        end
        nav(1'b0);
        nav(1'b0);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i]);
            dout[i] = tdo_seen;
            en_shift = en_seen;
        end
        nav(1'b1);
        nav(1'b0);
    endtask : scan
endmodule : bstap_tester

/* tb/testbench.sv */
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ns
module testbench;
    import bstap_pkg::*;
    // arbitrary neutral identification value
    localparam logic [31:0] TB_ID = 32'h0000_0001;
    localparam logic [114:0] P1 = {23{5'h13}};
    localparam logic [114:0] P2 = {23{5'h09}};
    localparam logic [114:0] W1 = {23{5'h0d}};
    localparam logic [114:0] W2 = {23{5'h06}};
    localparam logic [114:0] SYS = {23{5'h1a}};
    localparam logic [114:0] SYS2 = ~SYS;
    logic clk_in, nrst_in, trst_n_in, tck, tms, tdi, tdo, tdo_en;
    logic [BSTAP_BSR_LEN-1:0] pad_in, sys_data_in, pad_data_out;
    logic [BSTAP_EN_CELLS-1:0] sys_en_in, pad_en_out;
    logic [127:0] got;
    int fail_count, checks;
    bstap_top #(.ID_VALUE(TB_ID)) dut (.clk_in(clk_in), .nrst_in(nrst_in), .tck_in(tck), .tms_in(tms),
        .tdi_in(tdi), .trst_n_in(trst_n_in), .pad_in(pad_in), .sys_data_in(sys_data_in),
        .sys_en_in(sys_en_in), .tdo_out(tdo), .tdo_en_out(tdo_en), .pad_data_out(pad_data_out),
        .pad_en_out(pad_en_out));
    bstap_tester tester (.clk_in(clk_in), .tdo_in(tdo), .tdo_en_in(tdo_en), .tck_out(tck), .tms_out(tms),
        .tdi_out(tdi));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    function automatic logic [114:0] rev(input logic [114:0] v);
        return {<<{v}};
    endfunction : rev
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic settle();
        repeat (8) @(posedge clk_in);
    endtask : settle
    task automatic load_ir(input logic [3:0] code);
        tester.scan(1'b1, 4, {124'h0, code}, got);
        check("ir capture", got[1:0], 2'h1);
        settle();
    endtask : load_ir
    task automatic t_id();
        tester.idle();
        tester.scan(1'b0, 32, '0, got);
        check("id", got[31:0], TB_ID);
        check("tdo enable in shift", tester.en_shift, 1'b1);
        check("tdo enable idle", tester.en_seen, 1'b0);
        check("pins outside test", pad_data_out, SYS);
        $display("done id");
    endtask : t_id
    task automatic t_bypass();
        load_ir(BSTAP_OP_BYPASS);
        tester.scan(1'b0, 8, 128'hb4, got);
        check("bypass", got[7:0], 8'h68);
        for (int c = 2; c < 15; c++) begin
            load_ir(c[3:0]);
            tester.scan(1'b0, 3, 128'h5, got);
            check("reserved", got[2:0], 3'h2);
        end
        $display("done bypass");
    endtask : t_bypass
    task automatic t_sample();
        load_ir(BSTAP_OP_SAMPLE);
        tester.scan(1'b0, 116, {12'h0, rev(W1), 1'b1}, got);
        check("captured pads", got[114:0], rev(P1));
        check("chain length", got[115], 1'b1);
        settle();
        check("pins under sample", pad_data_out, SYS);
        $display("done sample");
    endtask : t_sample
    task automatic t_extest();
        pad_in <= P2;
        load_ir(BSTAP_OP_EXTEST);
        check("extest data", pad_data_out, W1);
        check("extest enable", pad_en_out, W1[114:112]);
        fork
            tester.scan(1'b0, 115, {13'h0, rev(W2)}, got);
            begin
                repeat (800) @(posedge clk_in);
                check("pins during shift", pad_data_out, W1);
            end
        join
        settle();
        check("extest capture", got[114:0], rev(P2));
        check("extest update", pad_data_out, W2);
        tester.idle();
        settle();
        check("idle hold", pad_data_out, W2);
        $display("done extest");
    endtask : t_extest
    task automatic t_tms_reset();
        tester.align();
        tester.nav(1'b1);
        tester.nav(1'b0);
        tester.nav(1'b0);
        tester.tick(1'b1, 1'b1);
        repeat (3) tester.nav(1'b1);
        settle();
        check("four high", pad_data_out, {P2[113:0], 1'b1});
        tester.align();
        tester.nav(1'b1);
        settle();
        check("five high data", pad_data_out, SYS);
        check("five high enable", pad_en_out, sys_en_in);
        repeat (3) tester.nav(1'b1);
        tester.nav(1'b0);
        tester.scan(1'b0, 32, '0, got);
        check("id after reset", got[31:0], TB_ID);
        load_ir(BSTAP_OP_EXTEST);
        check("cleared enables", pad_en_out, 3'h0);
        $display("done tms reset");
    endtask : t_tms_reset
    task automatic t_trst();
        @(posedge clk_in);
        trst_n_in <= 1'b0;
        sys_data_in <= SYS2;
        sys_en_in <= 3'h2;
        repeat (2) @(posedge clk_in);
        trst_n_in <= 1'b1;
        settle();
        check("trst data", pad_data_out, SYS2);
        check("trst enable", pad_en_out, 3'h2);
        tester.idle();
        tester.scan(1'b0, 32, '0, got);
        check("id after trst", got[31:0], TB_ID);
        $display("done trst");
    endtask : t_trst
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (90000) @(posedge clk_in);
        fail_count++;
        summarize();
    end
    initial begin
        nrst_in = 1'b0;
        trst_n_in = 1'b1;
        pad_in = P1;
        sys_data_in = SYS;
        sys_en_in = 3'h5;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        settle();
        t_id();
        t_bypass();
        t_sample();
        t_extest();
        t_tms_reset();
        t_trst();
        summarize();
    end
endmodule : testbench
